// [design/csf_drive.sv]
// drive end: cyclic synchronous position and velocity follower
// Contract
// RULE_01: master selects position with code 8
// RULE_02: master selects velocity with code 9
// RULE_03: controlword bits carry no mode meaning
// RULE_04: new target acts without controlword bit 4
// RULE_05: no ramps, setpoint tracked directly
// RULE_06: absolute setpoint, repeats change nothing
// RULE_07: master sends setpoint once per cycle
// RULE_08: master writes fresh target position each cycle
// RULE_09: master writes fresh target velocity each cycle
// RULE_10: cycle time is period times ten-power index
// RULE_11: only time index -3 accepted
// RULE_12: status bit 8 shows fieldbus sync
// RULE_13: status bit 12 shows target followed
// RULE_14: bit 10 reserved, bit 13 reserved velocity
// RULE_15: status bit 11 flags demand beyond limits
// RULE_16: bit 13 flags lasting following error
// RULE_17: following-error timeout counted in milliseconds
// RULE_18: position setpoint confined to software limits; here only with the clamp preset, the wrap preset passes the target unclamped
// RULE_19: range overrun handled per range preset
// RULE_20: quick-stop brakes with configured deceleration
// RULE_21: limit switches stay active in both modes
// RULE_22: actuals, following error, polarity readable
// RULE_23: without new setpoint keep last one
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "csf_map.svh"
module csf_drive
(
  input  wire logic               mclk,        // 125 MHz clock
  input  wire logic               rst_n,       // async reset, low
  csf_link_if.drive               link,        // object link
  input  wire csf_pkg::csf_word_t pos_actual,  // measured position
  input  wire csf_pkg::csf_word_t vel_actual,  // measured velocity
  input  wire logic               quick_stop,  // quick-stop request
  input  wire logic               lim_neg,     // negative limit switch
  input  wire logic               lim_pos,     // positive limit switch
  output var  csf_pkg::csf_word_t demand,      // position or velocity cmd
  output var  logic               demand_pos,  // demand is a position
  output var  logic               brake,       // quick-stop braking
  output var  csf_pkg::csf_word_t brake_decel, // deceleration to use
  output var  logic [7:0]         brake_option // quick-stop option
);
  import csf_pkg::*;
  csf_idx_t   mode;
  csf_word_t  ctrlword, tgt_pos, tgt_vel, lim_min, lim_max;
  csf_idx_t   range_opt, qs_option, ip_index;
  csf_word_t  fe_window, fe_timeout, qs_decel, ip_period;
  csf_word_t  next_demand, fe_actual, fe_abs, cyc_len, cyc_cnt;
  logic       sync_seen, in_sync, lim_hit, ferr, tgt_stop;
  logic [1:0] qs_sr, ln_sr, lp_sr;
  logic [15:0] status;
  logic       is_csp, is_csv, run;

  // clamp a signed position into the limit window
  function automatic csf_word_t csf_clamp(csf_word_t v, csf_word_t lo,
                                          csf_word_t hi);
    if ($signed(v) < $signed(lo))
      return lo;
    else if ($signed(v) > $signed(hi))
      return hi;
    else
      return v;
  endfunction

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  // two-stage sync of external pins
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      qs_sr <= 2'b00;
      ln_sr <= 2'b00;
      lp_sr <= 2'b00;
    end
    else
    begin
      qs_sr <= {qs_sr[0], quick_stop};
      ln_sr <= {ln_sr[0], lim_neg};
      lp_sr <= {lp_sr[0], lim_pos};
    end
  end

  // ------------------------------------------------------------
  // object writes
  // ------------------------------------------------------------
  // RULE_01: position mode code
  // RULE_02: velocity mode code
  assign is_csp = (mode == `CSF_MODE_CSP);
  assign is_csv = (mode == `CSF_MODE_CSV);

  // object store; repeat writes of a target are idempotent
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode       <= 8'h00;
      ctrlword   <= 32'h00000000;
      tgt_pos    <= 32'h00000000;
      tgt_vel    <= 32'h00000000;
      lim_min    <= 32'h80000000;
      lim_max    <= 32'h7FFFFFFF;
      range_opt  <= `CSF_RANGE_CLAMP;
      fe_window  <= 32'h00000100;
      fe_timeout <= 32'h0000000A;
      qs_decel   <= 32'h00000000;
      qs_option  <= 8'h02;
      ip_period  <= 32'h00000001;
      ip_index   <= `CSF_IP_INDEX_MS;
    end
    else if (link.req && link.wr && !link.ack)
    begin
      if (link.idx == `CSF_OBJ_MODE)
        mode <= link.wdata[7:0];
      else if (link.idx == `CSF_OBJ_CTRLWORD)
        ctrlword <= link.wdata;
      // RULE_06: absolute target simply overwritten
      else if (link.idx == `CSF_OBJ_TARGET_POS)
        tgt_pos <= link.wdata;
      else if (link.idx == `CSF_OBJ_TARGET_VEL)
        tgt_vel <= link.wdata;
      else if (link.idx == `CSF_OBJ_LIMIT_MIN)
        lim_min <= link.wdata;
      else if (link.idx == `CSF_OBJ_LIMIT_MAX)
        lim_max <= link.wdata;
      else if (link.idx == `CSF_OBJ_RANGE_OPT)
        range_opt <= link.wdata[7:0];
      else if (link.idx == `CSF_OBJ_FE_WINDOW)
        fe_window <= link.wdata;
      else if (link.idx == `CSF_OBJ_FE_TIMEOUT)
        fe_timeout <= link.wdata;
      else if (link.idx == `CSF_OBJ_QS_DECEL)
        qs_decel <= link.wdata;
      else if (link.idx == `CSF_OBJ_QS_OPTION)
        qs_option <= link.wdata[7:0];
      else if (link.idx == `CSF_OBJ_IP_PERIOD)
        ip_period <= link.wdata;
      // RULE_11: only index -3 is accepted
      else if (link.idx == `CSF_OBJ_IP_INDEX &&
               link.wdata[7:0] == `CSF_IP_INDEX_MS)
        ip_index <= link.wdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // cycle timing and sync
  // ------------------------------------------------------------
  // RULE_10: period in ms, index fixed at -3
  assign cyc_len = 32'(ip_period * `CSF_MS_CYCLES);

  // cycle counter, restarted by each master sync pulse
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cyc_cnt <= 32'h00000000;
    else if (link.sync)
      cyc_cnt <= 32'h00000000;
    else if (cyc_cnt != 32'hFFFFFFFF)
      cyc_cnt <= cyc_cnt + 32'h00000001;
  end

  // RULE_12: in sync while pulses arrive in time
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_seen <= 1'b0;
      in_sync   <= 1'b0;
    end
    else if (link.sync)
    begin
      sync_seen <= 1'b1;
      in_sync   <= sync_seen;
    end
    else if (cyc_cnt > cyc_len)
      in_sync <= 1'b0;
  end

  // ------------------------------------------------------------
  // setpoint path
  // ------------------------------------------------------------
  // RULE_03: ctrlword stored but gives no mode meaning
  // RULE_21: limit switches block motion toward them
  assign tgt_stop = (ln_sr[1] && $signed(tgt_vel) < 0) ||
                    (lp_sr[1] && $signed(tgt_vel) > 0);
  assign run = (is_csp || is_csv) && !qs_sr[1];

  // RULE_05: no ramp, demand is the setpoint
  // RULE_23: last setpoint held between writes
  always_comb
  begin
    next_demand = demand;
    if (is_csp)
    begin
      // RULE_18: confine to software limits unless the wrap preset is set
      // RULE_19: wrap or clamp per range preset
      if (range_opt == `CSF_RANGE_WRAP)
        next_demand = tgt_pos;
      else
        next_demand = csf_clamp(tgt_pos, lim_min, lim_max);
      if ((ln_sr[1] && $signed(next_demand) < $signed(pos_actual)) ||
          (lp_sr[1] && $signed(next_demand) > $signed(pos_actual)))
        next_demand = pos_actual;
    end
    else if (is_csv)
      next_demand = tgt_stop ? 32'h00000000 : tgt_vel;
  end

  // RULE_04: target acts with no controlword bit 4
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      demand     <= 32'h00000000;
      demand_pos <= 1'b0;
    end
    else if (run)
    begin
      demand     <= next_demand;
      demand_pos <= is_csp;
    end
  end

  // RULE_20: quick-stop braking with option and decel
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brake        <= 1'b0;
      brake_decel  <= 32'h00000000;
      brake_option <= 8'h00;
    end
    else
    begin
      brake        <= qs_sr[1] && (is_csp || is_csv);
      brake_decel  <= qs_decel;
      brake_option <= qs_option;
    end
  end

  // ------------------------------------------------------------
  // status
  // ------------------------------------------------------------
  assign fe_actual = 32'(demand - pos_actual);
  assign fe_abs    = fe_actual[31] ? 32'(-fe_actual) : fe_actual;

  // RULE_15: beyond software limits
  assign lim_hit = is_csp && ($signed(tgt_pos) < $signed(lim_min) ||
                              $signed(tgt_pos) > $signed(lim_max));

  csf_ferr_timer u_ferr
  (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .enable     (is_csp && run),
    .outside    (fe_abs > fe_window),
    .timeout_ms (fe_timeout),
    .ferr       (ferr)
  );

  // RULE_13: follow bit; RULE_14: bit 10 stays zero
  always_comb
  begin
    status = 16'h0000;
    status[`CSF_SW_SYNC]   = in_sync;
    status[`CSF_SW_LIMIT]  = lim_hit;
    status[`CSF_SW_FOLLOW] = run;
    // RULE_14: bit 13 reserved in velocity mode
    status[`CSF_SW_FERR]   = is_csp && ferr;
  end

  // RULE_22: readback with one-cycle ack
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.ack   <= 1'b0;
      link.rdata <= 32'h00000000;
    end
    else
    begin
      link.ack <= link.req && !link.ack;
      if (link.idx == `CSF_OBJ_STATUSWORD)
        link.rdata <= {16'h0000, status};
      else if (link.idx == `CSF_OBJ_POS_ACTUAL)
        link.rdata <= pos_actual;
      else if (link.idx == `CSF_OBJ_VEL_ACTUAL)
        link.rdata <= vel_actual;
      else if (link.idx == `CSF_OBJ_FE_ACTUAL)
        link.rdata <= is_csp ? fe_actual : 32'h00000000;
      else if (link.idx == `CSF_OBJ_POLARITY)
        link.rdata <= {31'h00000000, vel_actual[31]};
      else if (link.idx == `CSF_OBJ_DEMAND)
        link.rdata <= demand;
      else if (link.idx == `CSF_OBJ_MODE)
        link.rdata <= {24'h000000, mode};
      else if (link.idx == `CSF_OBJ_IP_PERIOD)
        link.rdata <= ip_period;
      else if (link.idx == `CSF_OBJ_IP_INDEX)
        link.rdata <= {24'h000000, ip_index};
      else
        link.rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// [design/csf_map.svh]
// register offsets, field positions and timing counts of the setpoint follower
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH
// object indices on the device link (word addresses)
`define CSF_OBJ_MODE       8'h00
`define CSF_OBJ_CTRLWORD   8'h01
`define CSF_OBJ_TARGET_POS 8'h02
`define CSF_OBJ_TARGET_VEL 8'h03
`define CSF_OBJ_LIMIT_MIN  8'h04
`define CSF_OBJ_LIMIT_MAX  8'h05
`define CSF_OBJ_RANGE_OPT  8'h06
`define CSF_OBJ_FE_WINDOW  8'h07
`define CSF_OBJ_FE_TIMEOUT 8'h08
`define CSF_OBJ_QS_DECEL   8'h09
`define CSF_OBJ_QS_OPTION  8'h0A
`define CSF_OBJ_IP_PERIOD  8'h0B
`define CSF_OBJ_IP_INDEX   8'h0C
`define CSF_OBJ_STATUSWORD 8'h10
`define CSF_OBJ_POS_ACTUAL 8'h11
`define CSF_OBJ_VEL_ACTUAL 8'h12
`define CSF_OBJ_FE_ACTUAL  8'h13
`define CSF_OBJ_POLARITY   8'h14
`define CSF_OBJ_DEMAND     8'h15
// operating mode codes
`define CSF_MODE_CSP       8'h08
`define CSF_MODE_CSV       8'h09
// accepted time index (-3, one millisecond base)
`define CSF_IP_INDEX_MS    8'hFD
// statusword bit positions
`define CSF_SW_SYNC        8
`define CSF_SW_LIMIT       11
`define CSF_SW_FOLLOW      12
`define CSF_SW_FERR        13
// one millisecond at 125 MHz: 1 ms * 125 MHz
`define CSF_MS_NS          1000000
`define CSF_CLK_NS         8
`define CSF_MS_CYCLES      (`CSF_MS_NS / `CSF_CLK_NS)
// controller register offsets on the avalon side (byte addresses)
`define CSF_AV_ADDR        8'h00
`define CSF_AV_WDATA       8'h04
`define CSF_AV_CMD         8'h08
`define CSF_AV_RDATA       8'h0C
`define CSF_AV_STATUS      8'h10
`define CSF_AV_PERIOD      8'h14
// controller cmd and status bits, and range preset codes
`define CSF_CMD_WRITE      0
`define CSF_CMD_READ       1
`define CSF_CMD_AUTO       2
`define CSF_ST_BUSY        0
`define CSF_ST_CYCLES      1
`define CSF_RANGE_CLAMP    8'h00
`define CSF_RANGE_WRAP     8'h01
`endif

// [design/csf_pkg.sv]
// types shared by both ends of the setpoint follower
`default_nettype none
package csf_pkg;
  typedef logic [31:0] csf_word_t;
  typedef logic [7:0]  csf_idx_t;
  typedef enum logic [1:0]
  {
    CSF_IDLE  = 2'b00,
    CSF_REQ   = 2'b01,
    CSF_WAIT  = 2'b10
  } csf_state_t;
endpackage
`default_nettype wire

// [design/csf_link_if.sv]
// object access link between the motion master and the drive
`timescale 1ns/10ps
`default_nettype none
interface csf_link_if;
  import csf_pkg::*;
  logic      req;    // access request level
  logic      wr;     // 1 write, 0 read
  csf_idx_t  idx;    // object index
  csf_word_t wdata;  // write data
  logic      ack;    // one-cycle answer
  csf_word_t rdata;  // read data with ack
  logic      sync;   // cycle start pulse from master
  modport master (output req, output wr, output idx, output wdata,
                  output sync, input ack, input rdata);
  modport drive  (input req, input wr, input idx, input wdata,
                  input sync, output ack, output rdata);
endinterface
`default_nettype wire

// [design/csf_ferr_timer.sv]
// following-error window timer counted in milliseconds
`timescale 1ns/10ps
`default_nettype none
`include "csf_map.svh"
module csf_ferr_timer
(
  input  wire logic             mclk,      // 125 MHz clock
  input  wire logic             rst_n,     // async reset, low
  input  wire logic             enable,    // position mode running
  input  wire logic             outside,   // error beyond window
  input  wire csf_pkg::csf_word_t timeout_ms, // timeout in ms
  output var  logic             ferr       // following error flag
);
  import csf_pkg::*;
  logic [16:0] tick;
  csf_word_t   ms_cnt;

  // millisecond prescaler, restarts when back in window
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tick <= 17'h00000;
    else if (!enable || !outside || tick == 17'(`CSF_MS_CYCLES - 1))
      tick <= 17'h00000;
    else
      tick <= tick + 17'h00001;
  end

  // RULE_17: count whole milliseconds
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ms_cnt <= 32'h00000000;
    else if (!enable || !outside)
      ms_cnt <= 32'h00000000;
    else if (tick == 17'(`CSF_MS_CYCLES - 1) && ms_cnt != 32'hFFFFFFFF)
      ms_cnt <= ms_cnt + 32'h00000001;
  end

  // RULE_16: flag once outside longer than timeout
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ferr <= 1'b0;
    else
      ferr <= enable && outside && (ms_cnt > timeout_ms);
  end
endmodule
`default_nettype wire

// [design/csf_master.sv]
// master end: avalon-controlled object access and cycle sync source
`timescale 1ns/10ps
`default_nettype none
`include "csf_map.svh"
module csf_master
(
  input  wire logic               mclk,           // 125 MHz clock
  input  wire logic               rst_n,          // async reset, low
  csf_link_if.master              link,           // object link
  input  wire logic [7:0]         avs_address,    // byte address
  input  wire logic               avs_read,       // read strobe
  input  wire logic               avs_write,      // write strobe
  input  wire csf_pkg::csf_word_t avs_writedata,  // write data
  output var  csf_pkg::csf_word_t avs_readdata,   // read data
  output var  logic               avs_waitrequest // stall
);
  import csf_pkg::*;
  csf_state_t st;
  csf_idx_t   a_idx;
  csf_word_t  a_wdata, a_rdata, period_ms, ms_cnt;
  logic [16:0] tick;
  logic       pend_wr, pend_rd, busy, done;

  // ------------------------------------------------------------
  // avalon slave, one wait cycle per access
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
  end

  // register writes and command pulses
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_idx     <= 8'h00;
      a_wdata   <= 32'h00000000;
      period_ms <= 32'h00000001;
      pend_wr   <= 1'b0;
      pend_rd   <= 1'b0;
    end
    else
    begin
      if (st == CSF_REQ)
      begin
        pend_wr <= 1'b0;
        pend_rd <= 1'b0;
      end
      if (avs_write && !avs_waitrequest)
      begin
        if (avs_address == `CSF_AV_ADDR)
          a_idx <= avs_writedata[7:0];
        else if (avs_address == `CSF_AV_WDATA)
          a_wdata <= avs_writedata;
        else if (avs_address == `CSF_AV_PERIOD)
          period_ms <= avs_writedata;
        else if (avs_address == `CSF_AV_CMD && !busy)
        begin
          pend_wr <= avs_writedata[`CSF_CMD_WRITE];
          pend_rd <= avs_writedata[`CSF_CMD_READ] &&
                     !avs_writedata[`CSF_CMD_WRITE];
        end
      end
    end
  end

  assign busy = (st != CSF_IDLE) || pend_wr || pend_rd;

  // register readback
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h00000000;
    else if (avs_address == `CSF_AV_ADDR)
      avs_readdata <= {24'h000000, a_idx};
    else if (avs_address == `CSF_AV_WDATA)
      avs_readdata <= a_wdata;
    else if (avs_address == `CSF_AV_RDATA)
      avs_readdata <= a_rdata;
    else if (avs_address == `CSF_AV_STATUS)
      avs_readdata <= {30'h00000000, done, busy};
    else if (avs_address == `CSF_AV_PERIOD)
      avs_readdata <= period_ms;
    else
      avs_readdata <= 32'h00000000;
  end

  // ------------------------------------------------------------
  // link access state machine
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st         <= CSF_IDLE;
      link.req   <= 1'b0;
      link.wr    <= 1'b0;
      link.idx   <= 8'h00;
      link.wdata <= 32'h00000000;
      a_rdata    <= 32'h00000000;
      done       <= 1'b0;
    end
    else
    begin
      case (st)
        CSF_IDLE:
          if (pend_wr || pend_rd)
          begin
            st <= CSF_REQ;
            done <= 1'b0;
          end
        CSF_REQ:
        begin
          link.req   <= 1'b1;
          link.wr    <= pend_wr;
          link.idx   <= a_idx;
          link.wdata <= a_wdata;
          st         <= CSF_WAIT;
        end
        CSF_WAIT:
          if (link.ack)
          begin
            link.req <= 1'b0;
            a_rdata  <= link.rdata;
            done     <= 1'b1;
            st       <= CSF_IDLE;
          end
        default:
          st <= CSF_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // cycle sync, one pulse every period_ms milliseconds
  // ------------------------------------------------------------
  // RULE_07: one setpoint cycle per pulse
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick      <= 17'h00000;
      ms_cnt    <= 32'h00000000;
      link.sync <= 1'b0;
    end
    else
    begin
      link.sync <= 1'b0;
      if (tick == 17'(`CSF_MS_CYCLES - 1))
      begin
        tick <= 17'h00000;
        if (ms_cnt + 32'h00000001 >= period_ms)
        begin
          ms_cnt    <= 32'h00000000;
          link.sync <= 1'b1;
        end
        else
          ms_cnt <= ms_cnt + 32'h00000001;
      end
      else
        tick <= tick + 17'h00001;
    end
  end
endmodule
`default_nettype wire

// [tb/csf_link_props.sv]
// link protocol checker for the setpoint follower
`timescale 1ns/10ps
`default_nettype none
`include "csf_map.svh"
module csf_link_props
(
  input wire logic               mclk,  // clock
  input wire logic               rst_n, // reset, low
  input wire logic               req,   // request
  input wire logic               wr,    // write
  input wire csf_pkg::csf_idx_t  idx,   // index
  input wire csf_pkg::csf_word_t wdata, // write data
  input wire logic               ack,   // answer
  input wire csf_pkg::csf_word_t rdata, // read data
  input wire logic               sync   // cycle pulse
);
  import csf_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ----------
  // handshake
  // ----------
  chk_ack_prompt: assert property (req && !ack |=> ack)
    else $error("ack late");
  chk_ack_single: assert property (ack |=> !ack)
    else $error("ack too long");
  chk_ack_has_req: assert property (ack |-> req)
    else $error("ack without req");
  chk_req_released: assert property (ack |=> !req)
    else $error("req held after ack");
  chk_req_held: assert property (req && !ack |=>
    $stable(idx) && $stable(wr) && $stable(wdata))
    else $error("request moved");
  chk_sync_gap: assert property (sync |-> ##1 !sync [*8])
    else $error("sync too close");
  chk_index_fixed: assert property (ack && !wr &&
    idx == `CSF_OBJ_IP_INDEX |-> rdata[7:0] == `CSF_IP_INDEX_MS)
    else $error("time index changed");
  chk_bit_reserved: assert property (ack && !wr &&
    idx == `CSF_OBJ_STATUSWORD |-> !rdata[10])
    else $error("reserved bit set");
  // main scenarios
  cover property (ack && wr);
  cover property (ack && !wr);
  cover property (sync);
endmodule
`default_nettype wire

// [tb/tb_cyclic_sync_setpoint_follower.sv]
// self-checking bench for both ends of the setpoint follower
`timescale 1ns/10ps
`default_nettype none
`include "csf_map.svh"
module tb_cyclic_sync_setpoint_follower;
  import csf_pkg::*;
  typedef struct packed
  {
    logic      w;
    csf_idx_t  i;
    csf_word_t d;
    csf_word_t m;
    csf_word_t e;
  } csf_row_t;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic       avs_read = 1'b0;
  logic       avs_write = 1'b0;
  csf_word_t  avs_writedata = 32'h0;
  csf_word_t  avs_readdata;
  logic       avs_waitrequest;
  csf_word_t  pos_actual = 32'h123;
  csf_word_t  vel_actual = 32'hFFFFFF00;
  logic       quick_stop = 1'b0;
  logic       lim_neg = 1'b0;
  logic       lim_pos = 1'b0;
  csf_word_t  demand;
  csf_word_t  brake_decel;
  csf_word_t  q;
  logic       demand_pos;
  logic       brake;
  logic [7:0] brake_option;
  int         fail_count = 0;
  int         num_checks = 0;
  int         cyc = 0;
  // object accesses: write, index, data, mask, expected
  csf_row_t   rows [0:14] = '{
    '{1'b1, 8'h00, 32'h8, 32'h0, 32'h0},
    '{1'b0, 8'h00, 32'h0, 32'hFF, 32'h8},
    '{1'b1, 8'h0C, 32'hFE, 32'h0, 32'h0},
    '{1'b0, 8'h0C, 32'h0, 32'hFF, 32'hFD},
    '{1'b0, 8'h0B, 32'h0, 32'hFF, 32'h1},
    '{1'b1, 8'h05, 32'h1000, 32'h0, 32'h0},
    '{1'b1, 8'h02, 32'h2000, 32'h0, 32'h0},
    '{1'b0, 8'h10, 32'h0, 32'h3C00, 32'h1800},
    '{1'b0, 8'h11, 32'h0, 32'hFFFFFFFF, 32'h123},
    '{1'b0, 8'h12, 32'h0, 32'hFFFFFFFF, 32'hFFFFFF00},
    '{1'b1, 8'h00, 32'h9, 32'h0, 32'h0},
    '{1'b0, 8'h10, 32'h0, 32'h3C00, 32'h1000},
    '{1'b0, 8'h14, 32'h0, 32'h1, 32'h1},
    '{1'b1, 8'h00, 32'h0, 32'h0, 32'h0},
    '{1'b0, 8'h10, 32'h0, 32'h1000, 32'h0}};
  csf_link_if link();
  csf_master i_csf_master
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .link(link),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );
  csf_drive i_csf_drive
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .link(link),
    .pos_actual(pos_actual),
    .vel_actual(vel_actual),
    .quick_stop(quick_stop),
    .lim_neg(lim_neg),
    .lim_pos(lim_pos),
    .demand(demand),
    .demand_pos(demand_pos),
    .brake(brake),
    .brake_decel(brake_decel),
    .brake_option(brake_option)
  );
  csf_link_props i_csf_link_props
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .req(link.req),
    .wr(link.wr),
    .idx(link.idx),
    .wdata(link.wdata),
    .ack(link.ack),
    .rdata(link.rdata),
    .sync(link.sync)
  );
  // ----------
  // tasks
  // ----------
  task end_of_test;
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task cmp_w(input csf_word_t got, input csf_word_t exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_b(input logic got, input logic exp);
    cmp_w({31'h0, got}, {31'h0, exp});
  endtask
  // one avalon access, held until waitrequest is seen low
  task av(input logic w, input logic [7:0] a, input csf_word_t d,
          output csf_word_t r);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // one object access over the link, waits for done
  task obj(input logic w, input csf_idx_t i, input csf_word_t d,
           output csf_word_t r);
    csf_word_t s;
    av(1'b1, `CSF_AV_ADDR, {24'h0, i}, s);
    av(1'b1, `CSF_AV_WDATA, d, s);
    av(1'b1, `CSF_AV_CMD, w ? 32'h1 : 32'h2, s);
    s = 32'h0;
    while (s[1:0] !== 2'b10) av(1'b0, `CSF_AV_STATUS, 32'h0, s);
    av(1'b0, `CSF_AV_RDATA, 32'h0, r);
  endtask
  // clock and hang guard; 26 object accesses of some 18 cycles each
  always #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  // ----------
  // sequence
  // ----------
  initial
  begin
    repeat (8) @(posedge mclk);
    cmp_b(avs_waitrequest, 1'b1);
    cmp_w(demand, 32'h0);
    rst_n <= 1'b1;
    foreach (rows[k])
    begin
      obj(rows[k].w, rows[k].i, rows[k].d, q);
      if (rows[k].m != 32'h0)
        cmp_w(q & rows[k].m, rows[k].e);
    end
    obj(1'b1, `CSF_OBJ_QS_DECEL, 32'h777, q);
    obj(1'b1, `CSF_OBJ_MODE, 32'h8, q);
    obj(1'b1, `CSF_OBJ_TARGET_POS, 32'h2000, q);
    obj(1'b1, `CSF_OBJ_TARGET_POS, 32'h2000, q);
    repeat (4) @(posedge mclk);
    cmp_w(demand, 32'h1000);
    cmp_b(demand_pos, 1'b1);
    obj(1'b0, `CSF_OBJ_DEMAND, 32'h0, q);
    cmp_w(q, 32'h1000);
    obj(1'b0, `CSF_OBJ_FE_ACTUAL, 32'h0, q);
    cmp_w(q, 32'hEDD);
    obj(1'b1, `CSF_OBJ_RANGE_OPT, 32'h1, q);
    cmp_w(demand, 32'h2000);
    // limit switches in both modes
    lim_pos <= 1'b1;
    repeat (4) @(posedge mclk);
    cmp_w(demand, 32'h123);
    obj(1'b1, `CSF_OBJ_MODE, 32'h9, q);
    obj(1'b1, `CSF_OBJ_TARGET_VEL, 32'h50, q);
    cmp_w(demand, 32'h0);
    lim_pos <= 1'b0;
    lim_neg <= 1'b1;
    repeat (4) @(posedge mclk);
    cmp_w(demand, 32'h50);
    cmp_b(demand_pos, 1'b0);
    quick_stop <= 1'b1;
    repeat (5) @(posedge mclk);
    cmp_b(brake, 1'b1);
    cmp_w(brake_decel, 32'h777);
    cmp_w({24'h0, brake_option}, 32'h2);
    obj(1'b0, `CSF_OBJ_STATUSWORD, 32'h0, q);
    cmp_w(q & 32'h1100, 32'h0);
    av(1'b0, 8'h1C, 32'h0, q);
    cmp_w(q, 32'h0);
    // reset in mid-run: outputs and objects back to defaults
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    cmp_w(demand, 32'h0);
    cmp_b(brake, 1'b0);
    cmp_b(avs_waitrequest, 1'b1);
    rst_n <= 1'b1;
    obj(1'b0, `CSF_OBJ_MODE, 32'h0, q);
    cmp_w(q, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
